// file: rtl/sadc_consts.svh
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes inclusion by bare name from every file that needs a figure; definitions only.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// Byte offsets of the register words, and address block numbers of the sample time and result arrays.
`define SADC_OFS_CTRL 8'h00
`define SADC_OFS_CHEN 8'h04
`define SADC_OFS_STATUS 8'h08
`define SADC_OFS_INTR 8'h0c
`define SADC_OFS_MASK 8'h10
`define SADC_OFS_LIM_LO 8'h14
`define SADC_OFS_LIM_HI 8'h18
`define SADC_BLK_SMP 3'h1
`define SADC_BLK_RES 3'h2

// Control word field positions.
`define SADC_CTRL_EN 0
`define SADC_CTRL_FW 1
`define SADC_CTRL_CONT 2
`define SADC_CTRL_REF_LSB 3
`define SADC_CTRL_BYP 5
`define SADC_CTRL_TEMP 6
`define SADC_CTRL_FWCH_LSB 8
`define SADC_CTRL_START 16

// Interrupt status and mask bit positions.
`define SADC_INT_CONV 0
`define SADC_INT_SCAN 1
`define SADC_INT_RANGE 2

// Reset values.
`define SADC_SMP_RST 8'h03
`define SADC_LIM_LO_RST 12'h000
`define SADC_LIM_HI_RST 12'hfff

// Timing: converter clock ceiling and conversion length in converter clocks; also result width and sensor mux select.
`define SADC_SYS_CLK_KHZ 100000
`define SADC_CONV_FMAX_KHZ 14500
`define SADC_CONV_DIV ((`SADC_SYS_CLK_KHZ + `SADC_CONV_FMAX_KHZ - 1) / `SADC_CONV_FMAX_KHZ)
`define SADC_CONV_CLKS 18
`define SADC_RES_BITS 12
`define SADC_TEMP_MUX 4'h8

`endif

// file: rtl/sadc_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes the constants header is compiled alongside.
package sadc_pkg;

    // Reference choice driven to the analog reference switch.
    typedef enum logic [1:0] {
        SADC_REF_VDD,
        SADC_REF_VDD_HALF,
        SADC_REF_INT,
        SADC_REF_EXT
    } sadc_ref_t;

    // Conversion engine phases.
    typedef enum logic [1:0] {
        SADC_ST_IDLE,
        SADC_ST_SAMPLE,
        SADC_ST_CONVERT
    } sadc_conv_st_t;

endpackage

// file: rtl/sadc_conv_if.sv
// Request and result carrier between the sequencer top and the conversion engine.
// Assumes both ends sit on the same system clock.
`timescale 1ns/10ps
interface sadc_conv_if;
    logic req;
    logic [2:0] ch;
    logic [7:0] samp;
    logic temp_sel;
    logic abort;
    logic take;
    logic done;
    logic [2:0] done_ch;
    logic [11:0] result;
    logic busy;

    modport ctl (output req, ch, samp, temp_sel, abort,
                 input take, done, done_ch, result, busy);
    modport conv (input req, ch, samp, temp_sel, abort,
                  output take, done, done_ch, result, busy);
endinterface

// file: rtl/sadc_clkdiv.sv
// Converter clock tick generator: one-cycle tick every DIV system clocks.
// Assumes the system clock and the active-low asynchronous reset.
`timescale 1ns/10ps
`include "sadc_consts.svh"
module sadc_clkdiv #(
    parameter int DIV = `SADC_CONV_DIV
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Tick out.
    output logic o_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } sadc_div_state_t;

    sadc_div_state_t s_r, s_nxt;

    // Rounding the divide up keeps the converter rate at or below its ceiling. [R1]
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == 8'(DIV - 1)) begin
            s_nxt.cnt = 8'h00;
            s_nxt.tick = 1'b1; // [R1]
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_tick = s_r.tick;
endmodule

// file: rtl/sadc_conv.sv
// Conversion engine: sample window, then a 12-bit successive approximation over 18 ticks.
// Assumes a comparator input that is high when the held input is at or above the trial code.
`timescale 1ns/10ps
`include "sadc_consts.svh"
module sadc_conv (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Converter clock tick and comparator.
    input wire logic i_tick,
    input wire logic i_cmp_above,
    // Sequencer side.
    sadc_conv_if.conv bus,
    // Analog controls.
    output logic [3:0] o_mux_sel,
    output logic o_sample,
    output logic [11:0] o_dac_code
);
    typedef struct packed {
        sadc_pkg::sadc_conv_st_t st;
        logic [7:0] cnt;
        logic [4:0] step;
        logic [11:0] code;
        logic [11:0] dac;
        logic [2:0] ch;
        logic [3:0] mux;
        logic sample;
        logic take;
        logic done;
        logic [11:0] result;
        logic [2:0] dch;
    } sadc_conv_state_t;

    sadc_conv_state_t s_r, s_nxt;

    // Engine phases; a waiting request is taken in the finishing cycle so no gap appears.
    always_comb begin
        logic keep;
        logic [11:0] bitv;
        keep = 1'b0;
        bitv = 12'h800 >> s_r.step;
        s_nxt = s_r;
        s_nxt.take = 1'b0;
        s_nxt.done = 1'b0;
        if (bus.abort) begin
            s_nxt.st = sadc_pkg::SADC_ST_IDLE; // [R11]
            s_nxt.sample = 1'b0;
        end else begin
            unique case (s_r.st)
                sadc_pkg::SADC_ST_IDLE: begin
                    keep = bus.req;
                end
                sadc_pkg::SADC_ST_SAMPLE: begin
                    if (i_tick) begin
                        if (s_r.cnt == 8'h00) begin
                            s_nxt.st = sadc_pkg::SADC_ST_CONVERT; // [R3]
                            s_nxt.sample = 1'b0;
                            s_nxt.step = 5'h00;
                            s_nxt.code = 12'h000;
                            s_nxt.dac = 12'h800;
                        end else begin
                            s_nxt.cnt = s_r.cnt - 8'h01; // [R8]
                        end
                    end
                end
                sadc_pkg::SADC_ST_CONVERT: begin
                    if (i_tick) begin
                        if (s_r.step < 5'(`SADC_RES_BITS)) begin
                            s_nxt.code = i_cmp_above ? s_r.dac : s_r.code;
                            s_nxt.dac = s_nxt.code | (bitv >> 1);
                        end
                        s_nxt.step = s_r.step + 5'h01;
                        if (s_r.step == 5'(`SADC_CONV_CLKS - 1)) begin
                            s_nxt.done = 1'b1; // [R1]
                            s_nxt.result = s_r.code;
                            s_nxt.dch = s_r.ch; // [R7]
                            s_nxt.st = sadc_pkg::SADC_ST_IDLE;
                            keep = bus.req; // [R5]
                        end
                    end
                end
            endcase
        end
        if (keep) begin
            s_nxt.take = 1'b1;
            s_nxt.ch = bus.ch;
            s_nxt.mux = (bus.temp_sel && bus.ch == 3'h7) ? `SADC_TEMP_MUX : {1'b0, bus.ch}; // [R10]
            s_nxt.cnt = bus.samp; // [R8]
            s_nxt.sample = 1'b1;
            s_nxt.st = sadc_pkg::SADC_ST_SAMPLE;
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.take = s_r.take;
    assign bus.done = s_r.done;
    assign bus.done_ch = s_r.dch;
    assign bus.result = s_r.result;
    assign bus.busy = (s_r.st != sadc_pkg::SADC_ST_IDLE);
    assign o_mux_sel = s_r.mux; // [R4]
    assign o_sample = s_r.sample;
    assign o_dac_code = s_r.dac;
endmodule

// file: rtl/sadc_seq_top.sv
// Top of the eight-channel converter sequencer: registers, scan control, buffers, interrupts.
// Assumes a plain register port with one-cycle strobes and synchronous analog status inputs.
//
// Overview of operation
// [R1] Converter clock at most 14.5 MHz; each conversion spans 18 converter clocks.
// [R2] Reference select picks supply, half supply, internal 1.024 V or external pin.
// [R3] The sample-and-hold window length is programmable before conversion starts.
// [R4] Eight sequencer channels, each bound to a fixed input pin.
// [R5] Scan steps through enabled channels with no idle cycles between them.
// [R6] A mode bit chooses state-machine scanning or firmware-selected channel.
// [R7] Each channel keeps its own latest result buffer.
// [R8] Each channel has its own sample time, applied whenever it converts.
// [R9] Results outside low/high limits raise an out-of-range interrupt at once.
// [R10] The temperature sensor can be selected as a conversion input.
// [R11] No conversions during deep sleep or hibernate.
// [R12] A control bit bypasses the internal reference amplifier through a fixed pin.
// [R13] Scan-complete flag and interrupt after the last enabled channel is buffered.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "sadc_consts.svh"
module sadc_seq_top #(
    parameter int CONV_DIV = `SADC_CONV_DIV
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Interrupt.
    output logic o_irq,
    // Power state and comparator.
    input wire logic i_deep_sleep,
    input wire logic i_cmp_above,
    // Analog controls.
    output logic [1:0] o_ref_sel,
    output logic o_ref_bypass,
    output logic o_temp_bias_en,
    output logic [3:0] o_mux_sel,
    output logic o_sample,
    output logic [11:0] o_dac_code
);
    typedef struct packed {
        logic en;
        logic fw;
        logic cont;
        sadc_pkg::sadc_ref_t ref_sel;
        logic byp;
        logic temp;
        logic [2:0] fw_ch;
        logic [7:0] chen;
        logic [2:0] intr;
        logic [2:0] mask;
        logic [11:0] lim_lo;
        logic [11:0] lim_hi;
        logic [7:0][7:0] smp;
        logic [7:0][11:0] res;
        logic [7:0] res_vld;
        logic pend_valid;
        logic [2:0] pend_ch;
        logic scan_run;
        logic [31:0] rdata;
        logic irq;
    } sadc_top_state_t;

    sadc_top_state_t s_r, s_nxt;
    logic tick;
    logic stop;

    sadc_conv_if cbus ();

    // Lowest enabled channel.
    function automatic logic [2:0] sadc_first_en(input logic [7:0] chen);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (chen[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Highest enabled channel, which ends a scan.
    function automatic logic [2:0] sadc_last_en(input logic [7:0] chen);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (chen[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Next enabled channel above ch; the top bit flags a wrap to the first.
    function automatic logic [3:0] sadc_next_en(input logic [7:0] chen, input logic [2:0] ch);
        logic [3:0] r;
        logic found;
        r = {1'b1, sadc_first_en(chen)};
        found = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (!found && i > int'(ch) && chen[i]) begin
                r = {1'b0, 3'(i)};
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // Converter tick; the divide keeps the converter clock under its ceiling.
    sadc_clkdiv #(
        .DIV(CONV_DIV)
    ) u_div (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .o_tick(tick)
    );

    // Conversion engine.
    sadc_conv u_conv (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_tick(tick),
        .i_cmp_above(i_cmp_above),
        .bus(cbus),
        .o_mux_sel(o_mux_sel),
        .o_sample(o_sample),
        .o_dac_code(o_dac_code)
    );

    // The converter loses its fast clock in deep sleep and hibernate, so work is dropped.
    assign stop = !s_r.en || i_deep_sleep; // [R11]

    // Request to the engine; once a scan channel is taken, the pending channel moves to the next enabled one.
    assign cbus.req = s_r.pend_valid && !stop;
    assign cbus.ch = s_r.pend_ch;
    assign cbus.samp = s_r.smp[s_r.pend_ch]; // [R8]
    assign cbus.temp_sel = s_r.temp;
    assign cbus.abort = stop;

    // Register writes, sequencing, buffering and interrupt status.
    always_comb begin
        logic [2:0] set;
        logic [2:0] clr;
        logic [3:0] nx;
        logic [2:0] idx;
        set = 3'h0;
        clr = 3'h0;
        nx = 4'h0;
        idx = i_addr[4:2];
        s_nxt = s_r;

        // Advance the pending channel once the engine has taken it.
        if (cbus.take) begin
            if (s_r.fw) begin
                s_nxt.pend_valid = 1'b0; // [R6]
            end else begin
                nx = sadc_next_en(s_r.chen, s_r.pend_ch); // [R5]
                if (nx[3] && !s_r.cont) begin
                    s_nxt.pend_valid = 1'b0;
                end else begin
                    s_nxt.pend_ch = nx[2:0];
                end
            end
        end

        // Finished conversion: buffer it, test the limits, and detect the scan end.
        if (cbus.done) begin
            s_nxt.res[cbus.done_ch] = cbus.result; // [R7]
            s_nxt.res_vld[cbus.done_ch] = 1'b1;
            set[`SADC_INT_CONV] = 1'b1;
            if (cbus.result < s_r.lim_lo || cbus.result > s_r.lim_hi) begin
                set[`SADC_INT_RANGE] = 1'b1; // [R9]
            end
            if (!s_r.fw && cbus.done_ch == sadc_last_en(s_r.chen)) begin
                set[`SADC_INT_SCAN] = 1'b1; // [R13]
                if (!s_nxt.pend_valid) begin
                    s_nxt.scan_run = 1'b0;
                end
            end
        end

        // Register writes; a start written here overrides the advance above.
        if (i_wr) begin
            unique case (i_addr[7:5])
                `SADC_BLK_SMP: s_nxt.smp[idx] = i_wdata[7:0]; // [R8]
                `SADC_BLK_RES: ;
                3'h0: begin
                    unique case (i_addr)
                        `SADC_OFS_CTRL: begin
                            s_nxt.en = i_wdata[`SADC_CTRL_EN];
                            s_nxt.fw = i_wdata[`SADC_CTRL_FW]; // [R6]
                            s_nxt.cont = i_wdata[`SADC_CTRL_CONT];
                            s_nxt.ref_sel = sadc_pkg::sadc_ref_t'(
                                i_wdata[`SADC_CTRL_REF_LSB +: 2]); // [R2]
                            s_nxt.byp = i_wdata[`SADC_CTRL_BYP]; // [R12]
                            s_nxt.temp = i_wdata[`SADC_CTRL_TEMP]; // [R10]
                            s_nxt.fw_ch = i_wdata[`SADC_CTRL_FWCH_LSB +: 3];
                            if (i_wdata[`SADC_CTRL_START] && i_wdata[`SADC_CTRL_EN]) begin
                                if (i_wdata[`SADC_CTRL_FW]) begin
                                    s_nxt.pend_ch = i_wdata[`SADC_CTRL_FWCH_LSB +: 3]; // [R6]
                                    s_nxt.pend_valid = 1'b1;
                                end else if (s_nxt.chen != 8'h00) begin
                                    s_nxt.pend_ch = sadc_first_en(s_nxt.chen); // [R5]
                                    s_nxt.pend_valid = 1'b1;
                                    s_nxt.scan_run = 1'b1;
                                end
                            end
                        end
                        `SADC_OFS_CHEN: s_nxt.chen = i_wdata[7:0];
                        `SADC_OFS_INTR: clr = i_wdata[2:0];
                        `SADC_OFS_MASK: s_nxt.mask = i_wdata[2:0];
                        `SADC_OFS_LIM_LO: s_nxt.lim_lo = i_wdata[11:0]; // [R9]
                        `SADC_OFS_LIM_HI: s_nxt.lim_hi = i_wdata[11:0]; // [R9]
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // Disable or sleep drops pending work; a start written with enable survives unless deep sleep is on.
        if (!s_nxt.en || i_deep_sleep) begin
            s_nxt.pend_valid = 1'b0; // [R11]
            s_nxt.scan_run = 1'b0;
        end

        // Sticky status: a new event wins over a clear in the same cycle.
        s_nxt.intr = (s_r.intr & ~clr) | set;
        s_nxt.irq = |(s_nxt.intr & s_nxt.mask);

        // Read data stand only in the cycle after the read strobe.
        s_nxt.rdata = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr[7:5])
                `SADC_BLK_SMP: s_nxt.rdata = {24'h00_0000, s_r.smp[idx]};
                `SADC_BLK_RES: s_nxt.rdata = {s_r.res_vld[idx], 19'h0_0000, s_r.res[idx]}; // [R7]
                3'h0: begin
                    unique case (i_addr)
                        `SADC_OFS_CTRL: s_nxt.rdata = {21'h00_0000, s_r.fw_ch, 1'b0, s_r.temp,
                            s_r.byp, s_r.ref_sel, s_r.cont, s_r.fw, s_r.en};
                        `SADC_OFS_CHEN: s_nxt.rdata = {24'h00_0000, s_r.chen};
                        `SADC_OFS_STATUS: s_nxt.rdata = {23'h00_0000, i_deep_sleep, 1'b0,
                            cbus.done_ch, 2'h0, s_r.scan_run, cbus.busy | s_r.pend_valid};
                        `SADC_OFS_INTR: s_nxt.rdata = {29'h0000_0000, s_r.intr};
                        `SADC_OFS_MASK: s_nxt.rdata = {29'h0000_0000, s_r.mask};
                        `SADC_OFS_LIM_LO: s_nxt.rdata = {20'h0_0000, s_r.lim_lo};
                        `SADC_OFS_LIM_HI: s_nxt.rdata = {20'h0_0000, s_r.lim_hi};
                        default: s_nxt.rdata = 32'h0000_0000;
                    endcase
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register with documented reset values.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
            s_r.lim_lo <= `SADC_LIM_LO_RST;
            s_r.lim_hi <= `SADC_LIM_HI_RST;
            s_r.smp <= {8{`SADC_SMP_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign o_rdata = s_r.rdata;
    assign o_irq = s_r.irq;
    assign o_ref_sel = s_r.ref_sel; // [R2]
    assign o_ref_bypass = s_r.byp; // [R12]
    assign o_temp_bias_en = s_r.temp; // [R10]
endmodule

// file: bench/sadc_seq_asserts.sv
// Concurrent checks on the ports of the converter sequencer top.
// Assumes one system clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
module sadc_seq_asserts #(
    parameter int CONV_DIV = 7
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Interrupt, power state and comparator.
    input wire logic o_irq,
    input wire logic i_deep_sleep,
    input wire logic i_cmp_above,
    // Analog controls.
    input wire logic [1:0] o_ref_sel,
    input wire logic o_ref_bypass,
    input wire logic o_temp_bias_en,
    input wire logic [3:0] o_mux_sel,
    input wire logic o_sample,
    input wire logic [11:0] o_dac_code
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // Cycles since the window closed; aborts and control writes disarm it as they cut conversions.
    logic [15:0] gap_r;
    logic armed_r;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_r <= 16'h0000;
            armed_r <= 1'b0;
        end else if (i_deep_sleep || (i_wr && i_addr == 8'h00)) begin
            gap_r <= 16'h0000;
            armed_r <= 1'b0;
        end else if (o_sample) begin
            gap_r <= 16'h0000;
            armed_r <= 1'b1;
        end else if (gap_r != 16'hffff) begin
            gap_r <= gap_r + 16'h0001;
        end
    end

    property p_conv_len;
        $rose(o_sample) && armed_r |-> gap_r >= 16'(17 * CONV_DIV);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion shorter than its converter clock count");
    property p_ref_follow;
        i_wr && i_addr == 8'h00 ##1 !(i_wr && i_addr == 8'h00) |=>
            o_ref_sel == $past(i_wdata[4:3], 2);
    endproperty
    a_ref_follow: assert property (p_ref_follow)
        else $error("reference select does not follow control write");
    property p_mux_hold;
        o_sample && $past(o_sample) |-> $stable(o_mux_sel);
    endproperty
    a_mux_hold: assert property (p_mux_hold)
        else $error("mux select moved inside the sample window");
    property p_mux_range;
        o_mux_sel <= 4'h8;
    endproperty
    a_mux_range: assert property (p_mux_range)
        else $error("mux select outside the fixed inputs");
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data present without a read");
    property p_temp_mux;
        $rose(o_sample) && o_mux_sel == 4'h8 |-> $past(o_temp_bias_en);
    endproperty
    a_temp_mux: assert property (p_temp_mux)
        else $error("sensor selected with its bias off");
    property p_sleep_quiet;
        i_deep_sleep && $past(i_deep_sleep) && $past(i_deep_sleep, 2) |-> !o_sample;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("sampling during deep sleep");
    property p_bypass_follow;
        i_wr && i_addr == 8'h00 ##1 !(i_wr && i_addr == 8'h00) |=>
            o_ref_bypass == $past(i_wdata[5], 2);
    endproperty
    a_bypass_follow: assert property (p_bypass_follow)
        else $error("bypass does not follow control write");
endmodule

bind sadc_seq_top sadc_seq_asserts #(.CONV_DIV(CONV_DIV)) u_asserts (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_deep_sleep(i_deep_sleep),
    .i_cmp_above(i_cmp_above), .o_ref_sel(o_ref_sel), .o_ref_bypass(o_ref_bypass),
    .o_temp_bias_en(o_temp_bias_en), .o_mux_sel(o_mux_sel), .o_sample(o_sample),
    .o_dac_code(o_dac_code));

// file: bench/sadc_analog_model.sv
// Analog side: eight fixed input pins and the temperature sensor feeding the comparator.
// Assumes an ideal comparator; the held level does not move during a conversion.
`timescale 1ns/10ps
module sadc_analog_model (
    // Mux select and trial code from the converter.
    input wire logic [3:0] i_mux_sel,
    input wire logic [11:0] i_dac_code,
    // Levels of the pins and, at index 8, of the sensor.
    input wire logic [11:0] i_level [9],
    // Comparator decision.
    output logic o_cmp_above
);
    // Unused selects toggle with the trial code so a stray select cannot pass as a level.
    always_comb begin
        if (i_mux_sel <= 4'h8) begin
            o_cmp_above = (i_level[i_mux_sel] >= i_dac_code);
        end else begin
            o_cmp_above = i_dac_code[0];
        end
    end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the converter sequencer through its register port.
// Assumes the analog model on the comparator and a short converter clock divider.
`timescale 1ns/10ps
module testbench;
    localparam int DIV = 2;
    logic i_sys_clk, i_reset_n, i_wr, i_rd, i_deep_sleep, cmp, o_irq, o_sample;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, ctrl;
    logic [1:0] ref_sel;
    logic bypass, temp_en;
    logic [3:0] mux;
    logic [11:0] dac, lvl [9];
    int errors = 0, checks = 0, scnt = 0, rises = 0, ch, s0;
    logic prev = 1'b0;

    sadc_seq_top #(.CONV_DIV(DIV)) uut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .i_deep_sleep(i_deep_sleep), .i_cmp_above(cmp), .o_ref_sel(ref_sel),
        .o_ref_bypass(bypass), .o_temp_bias_en(temp_en), .o_mux_sel(mux),
        .o_sample(o_sample), .o_dac_code(dac));
    sadc_analog_model u_model (.i_mux_sel(mux), .i_dac_code(dac), .i_level(lvl),
        .o_cmp_above(cmp));

    // Clock of 10 ns period.
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // Sample window length and window starts, counted to judge timing from outside.
    always @(posedge i_sys_clk) begin
        prev <= o_sample;
        if (o_sample === 1'b1) scnt <= scnt + 1;
        if (o_sample === 1'b1 && prev !== 1'b1) rises <= rises + 1;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after it.
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(n, e, o_rdata);
    endtask

    task automatic wait_irq;
        for (int n = 0; n < 400 && o_irq !== 1'b1; n++) begin
            @(posedge i_sys_clk);
            #1;
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hung test is cut off long after all tests should have ended.
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        $display("Error watchdog expected end seen timeout");
        summarize();
    end

    initial begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_deep_sleep = 1'b0;
        for (int k = 0; k < 9; k++) lvl[k] = 12'h0d3 + 12'(12'h1c0 * k);
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        rd_chk("lim_lo", 8'h14, 32'h0);
        rd_chk("lim_hi", 8'h18, 32'h0000_0fff);
        rd_chk("smp0", 8'h20, 32'h3);
        rd_chk("unmapped", 8'h1c, 32'h0);
        $display("test reset values done");
        wr(8'h14, 32'h100);
        wr(8'h18, 32'he00);
        wr(8'h10, 32'h1);
        // Pass 8 converts the sensor in place of channel 7; passes 0 and 8 leave the range.
        for (int c = 0; c < 9; c++) begin
            ch = (c == 8) ? 7 : c;
            wr(8'(8'h20 + 4 * ch), 32'(c));
            ctrl = 32'h0001_0003 | (32'(ch) << 8);
            if (c == 8) ctrl[6] = 1'b1;
            s0 = scnt;
            wr(8'h00, ctrl);
            wait_irq();
            chk("sample_len", 1, scnt - s0 > c * DIV && scnt - s0 <= (c + 1) * DIV + 1);
            rd_chk("result", 8'(8'h40 + 4 * ch), 32'h8000_0000 | 32'(lvl[c]));
            rd_chk("intr", 8'h0c, (c == 0 || c == 8) ? 32'h5 : 32'h1);
            wr(8'h0c, 32'h7);
            rd_chk("intr_clr", 8'h0c, 32'h0);
        end
        wr(8'h44, 32'h0);
        rd_chk("result_ro", 8'h44, 32'h8000_0293);
        $display("test firmware conversions done");
        for (int k = 0; k < 8; k++) lvl[k] = 12'hfff - 12'(12'h123 * k);
        wr(8'h04, 32'ha4);
        wr(8'h10, 32'h2);
        s0 = rises;
        wr(8'h00, 32'h0001_0001);
        wait_irq();
        chk("scan_steps", 3, rises - s0);
        rd_chk("intr_scan", 8'h0c, 32'h3);
        rd_chk("scan_ch2", 8'h48, 32'h8000_0db9);
        rd_chk("scan_ch5", 8'h54, 32'h8000_0a50);
        rd_chk("scan_ch7", 8'h5c, 32'h8000_080a);
        rd_chk("skip_ch3", 8'h4c, 32'h8000_0613);
        wr(8'h0c, 32'h7);
        $display("test scan done");
        wr(8'h10, 32'h7);
        wr(8'h00, 32'h0001_0103);
        repeat (4) @(posedge i_sys_clk);
        i_deep_sleep <= 1'b1;
        repeat (150) @(posedge i_sys_clk);
        rd_chk("sleep_abort", 8'h0c, 32'h0);
        wr(8'h00, 32'h0001_0103);
        repeat (150) @(posedge i_sys_clk);
        rd_chk("sleep_block", 8'h0c, 32'h0);
        chk("sleep_irq", 0, o_irq);
        i_deep_sleep <= 1'b0;
        $display("test deep sleep done");
        for (int r = 0; r < 4; r++) begin
            wr(8'h00, 32'h21 | (32'(r) << 3));
            @(posedge i_sys_clk);
            #1;
            chk("ref_sel", 32'(r), 32'(ref_sel));
            chk("bypass", 1, 32'(bypass));
        end
        $display("test reference done");
        summarize();
    end
endmodule
